// ==== core/qci_pkg.sv ====
// Package: register map, field positions and reset values for the quadrature counter
package qci_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [4:0] OFF_CTRL   = 5'h00;
	localparam logic [4:0] OFF_COUNT  = 5'h04;
	localparam logic [4:0] OFF_GEN_A  = 5'h08;
	localparam logic [4:0] OFF_GEN_B  = 5'h0C;
	localparam logic [4:0] OFF_STATUS = 5'h10;
	localparam logic [4:0] OFF_IRQ_EN = 5'h14;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_MODE_BIT  = 0;
	localparam int CTRL_CLRA_BIT  = 1;
	localparam int CTRL_CHAN_LSB  = 4;
	localparam int CTRL_CHAN_W    = 3;
	localparam int CTRL_W         = 7;

	// Channels on which phase counting may run
	localparam logic [2:0] CHAN_1 = 3'h1;
	localparam logic [2:0] CHAN_2 = 3'h2;
	localparam logic [2:0] CHAN_4 = 3'h4;
	localparam logic [2:0] CHAN_5 = 3'h5;

	// ----------------------------------------------------------------
	// Status and enable layout (same positions in both registers)
	// ----------------------------------------------------------------
	localparam int ST_MATCH_A = 0;
	localparam int ST_MATCH_B = 1;
	localparam int ST_OVF     = 4;
	localparam int ST_UNF     = 5;
	localparam int ST_DIR     = 7;
	localparam int ST_W       = 8;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int          CNT_W       = 16;
	localparam logic [15:0] CNT_MAX     = 16'hFFFF;
	localparam logic [15:0] CNT_RST     = 16'h0000;
	localparam logic [15:0] GEN_RST     = 16'hFFFF;
	localparam logic [6:0]  CTRL_RST    = 7'h00;
	localparam logic [7:0]  ST_RST      = 8'h00;
	localparam logic [7:0]  IRQ_EN_RST  = 8'h00;
	localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

	// Fixed in-channel order of interrupt sources
	localparam logic [1:0] SRC_MATCH_A = 2'h0;
	localparam logic [1:0] SRC_MATCH_B = 2'h1;
	localparam logic [1:0] SRC_OVF     = 2'h2;
	localparam logic [1:0] SRC_UNF     = 2'h3;

	// Count step pulses of one decoder
	typedef struct packed {
		logic up;
		logic dn;
	} qci_step_t;

	// Sticky event flags
	typedef struct packed {
		logic match_a;
		logic match_b;
		logic ovf;
		logic unf;
	} qci_evt_t;

endpackage

// ==== core/qci_phase_dec.sv ====
// Two-phase decoder: synchroniser, edge detect and mode 4 count rules
`timescale 1ns/1ps
`default_nettype none

module qci_phase_dec
(
	input  wire logic              clock_i,  // Peripheral clock
	input  wire logic              rst_i,    // Async reset, high
	input  wire logic              pha_i,    // A phase pin, async
	input  wire logic              phb_i,    // B phase pin, async
	output qci_pkg::qci_step_t     step_o    // One-cycle count steps
);

	logic [1:0] meta_r,  meta_nxt;   // First stage, read only by stage two
	logic [1:0] sync_r,  sync_nxt;   // Second stage, safe to use
	logic [1:0] prev_r,  prev_nxt;   // Previous sample for edge detect
	qci_pkg::qci_step_t step_r, step_nxt;
	logic       b_rise;
	logic       b_fall;

	// ----------------------------------------------------------------
	// Synchroniser and count rules
	// ----------------------------------------------------------------
	// Next values; A edges deliberately produce no step
	always_comb
	begin
		meta_nxt = {phb_i, pha_i};
		sync_nxt = meta_r;
		prev_nxt = sync_r;
		b_rise   = sync_r[1] & ~prev_r[1];
		b_fall   = ~sync_r[1] & prev_r[1];
		step_nxt.up = (b_rise & sync_r[0]) | (b_fall & ~sync_r[0]);
		step_nxt.dn = (b_fall & sync_r[0]) | (b_rise & ~sync_r[0]);
	end

	// Register stage
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta_r <= 2'b00;
			sync_r <= 2'b00;
			prev_r <= 2'b00;
			step_r <= '0;
		end
		else
		begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
			prev_r <= prev_nxt;
			step_r <= step_nxt;
		end
	end

	assign step_o = step_r;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	// A edge with B steady never steps the counter
	AST_A_IGNORED: assert property ((sync_r[0] != prev_r[0]) && (sync_r[1] == prev_r[1]) |=>
		!step_r.up && !step_r.dn)
		else $error("step produced on an A edge");

	// Up and down steps never together
	AST_STEP_EXCL: assert property (!(step_r.up && step_r.dn))
		else $error("up and down step together");

endmodule

`default_nettype wire

// ==== core/qci_counter.sv ====
// Quadrature channel counter with flags, interrupt logic and Avalon-MM registers
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module qci_counter
(
	input  wire logic        clock_i,          // 100 MHz peripheral clock
	input  wire logic        rst_i,            // Async reset, high
	input  wire logic        ext_clk_in_a,     // Encoder pin A
	input  wire logic        ext_clk_in_b,     // Encoder pin B
	input  wire logic        ext_clk_in_c,     // Encoder pin C
	input  wire logic        ext_clk_in_d,     // Encoder pin D
	input  wire logic [4:0]  avs_address,      // Byte address
	input  wire logic        avs_read,         // Read request
	input  wire logic        avs_write,        // Write request
	input  wire logic [31:0] avs_writedata,    // Write data
	input  wire logic [3:0]  avs_byteenable,   // Byte lanes
	output logic [31:0]      avs_readdata,     // Read data, registered
	output logic             avs_waitrequest,  // Stall until answered
	output logic             irq_o,            // Level interrupt
	output logic [1:0]       irq_src_o,        // Highest pending source
	output logic             xfer_start_o,     // Transfer controller start
	output logic             dma_start_o       // DMA controller start
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	qci_pkg::qci_step_t   step_ab, step_cd, step;
	logic [6:0]           ctrl_r,   ctrl_nxt;
	logic [15:0]          count_r,  count_nxt;
	logic [15:0]          gen_a_r,  gen_a_nxt;
	logic [15:0]          gen_b_r,  gen_b_nxt;
	qci_pkg::qci_evt_t    flag_r,   flag_nxt;
	logic                 dir_r,    dir_nxt;
	logic [7:0]           irq_en_r, irq_en_nxt;
	logic                 ack_r,    ack_nxt;
	logic [31:0]          rdata_r,  rdata_nxt;
	qci_pkg::qci_evt_t    evt;
	logic [7:0]           status;
	logic [7:0]           pend;
	logic [2:0]           chan;
	logic                 run;
	logic                 wr_do;
	logic [15:0]          step_val;
	logic                 stepped;

	// ----------------------------------------------------------------
	// Pin decoders, one per pin pair
	// ----------------------------------------------------------------
	qci_phase_dec u_dec_ab
	(
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.pha_i   (ext_clk_in_a),
		.phb_i   (ext_clk_in_b),
		.step_o  (step_ab)
	);

	qci_phase_dec u_dec_cd
	(
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.pha_i   (ext_clk_in_c),
		.phb_i   (ext_clk_in_d),
		.step_o  (step_cd)
	);

	// Pin pair and legal channel select; other channels never count
	always_comb
	begin
		chan = ctrl_r[qci_pkg::CTRL_CHAN_LSB +: qci_pkg::CTRL_CHAN_W];
		run  = ctrl_r[qci_pkg::CTRL_MODE_BIT];
		step = '0;
		if (chan == qci_pkg::CHAN_1 || chan == qci_pkg::CHAN_5)
			step = step_ab;
		else if (chan == qci_pkg::CHAN_2 || chan == qci_pkg::CHAN_4)
			step = step_cd;
		else
			run = 1'b0;
		if (!run)
			step = '0;
	end

	// ----------------------------------------------------------------
	// Counter, compare events and flags
	// ----------------------------------------------------------------
	// Write is taken on the edge where waitrequest is seen low
	assign wr_do = ack_r & avs_write;

	// Step value; compare and clear work as in normal counting
	always_comb
	begin
		stepped  = step.up | step.dn;
		step_val = step.up ? count_r + 16'h0001 : count_r - 16'h0001;
		evt.match_a = stepped && step_val == gen_a_r;
		evt.match_b = stepped && step_val == gen_b_r;
		evt.ovf     = step.up && count_r == qci_pkg::CNT_MAX;
		evt.unf     = step.dn && count_r == qci_pkg::CNT_RST;
		count_nxt = count_r;
		if (stepped)
		begin
			count_nxt = step_val;
			if (evt.match_a && ctrl_r[qci_pkg::CTRL_CLRA_BIT])
				count_nxt = qci_pkg::CNT_RST;
		end
		// Software write wins over a step landing in the same cycle
		if (wr_do && avs_address == qci_pkg::OFF_COUNT)
		begin
			if (avs_byteenable[0])
				count_nxt[7:0] = avs_writedata[7:0];
			if (avs_byteenable[1])
				count_nxt[15:8] = avs_writedata[15:8];
		end
		dir_nxt = step.up ? 1'b1 : (step.dn ? 1'b0 : dir_r);
	end

	// Sticky flags: write one to clear, a new event wins over the clear
	always_comb
	begin
		flag_nxt = flag_r;
		if (wr_do && avs_address == qci_pkg::OFF_STATUS && avs_byteenable[0])
		begin
			if (avs_writedata[qci_pkg::ST_MATCH_A])
				flag_nxt.match_a = 1'b0;
			if (avs_writedata[qci_pkg::ST_MATCH_B])
				flag_nxt.match_b = 1'b0;
			if (avs_writedata[qci_pkg::ST_OVF])
				flag_nxt.ovf = 1'b0;
			if (avs_writedata[qci_pkg::ST_UNF])
				flag_nxt.unf = 1'b0;
		end
		flag_nxt = flag_nxt | evt;
	end

	// ----------------------------------------------------------------
	// Interrupt and transfer requests
	// ----------------------------------------------------------------
	always_comb
	begin
		status = '0;
		status[qci_pkg::ST_MATCH_A] = flag_r.match_a;
		status[qci_pkg::ST_MATCH_B] = flag_r.match_b;
		status[qci_pkg::ST_OVF]     = flag_r.ovf;
		status[qci_pkg::ST_UNF]     = flag_r.unf;
		status[qci_pkg::ST_DIR]     = dir_r;
		pend = status & irq_en_r;
		pend[qci_pkg::ST_DIR] = 1'b0;
		// Fixed order inside the channel; cross-channel order is external
		if (pend[qci_pkg::ST_MATCH_A])
			irq_src_o = qci_pkg::SRC_MATCH_A;
		else if (pend[qci_pkg::ST_MATCH_B])
			irq_src_o = qci_pkg::SRC_MATCH_B;
		else if (pend[qci_pkg::ST_OVF])
			irq_src_o = qci_pkg::SRC_OVF;
		else
			irq_src_o = qci_pkg::SRC_UNF;
	end

	assign irq_o       = |pend;
	assign xfer_start_o = pend[qci_pkg::ST_MATCH_A] | pend[qci_pkg::ST_MATCH_B];
	assign dma_start_o = pend[qci_pkg::ST_MATCH_A];

	// ----------------------------------------------------------------
	// Avalon-MM slave, one wait state on every access
	// ----------------------------------------------------------------
	// Read data is captured on the same edge where waitrequest drops
	always_comb
	begin
		ack_nxt    = (avs_read | avs_write) & ~ack_r;
		rdata_nxt  = rdata_r;
		ctrl_nxt   = ctrl_r;
		gen_a_nxt  = gen_a_r;
		gen_b_nxt  = gen_b_r;
		irq_en_nxt = irq_en_r;
		if (avs_read && !ack_r)
		begin
			unique case (avs_address)
				qci_pkg::OFF_CTRL:   rdata_nxt = {25'h000_0000, ctrl_r};
				qci_pkg::OFF_COUNT:  rdata_nxt = {16'h0000, count_r};
				qci_pkg::OFF_GEN_A:  rdata_nxt = {16'h0000, gen_a_r};
				qci_pkg::OFF_GEN_B:  rdata_nxt = {16'h0000, gen_b_r};
				qci_pkg::OFF_STATUS: rdata_nxt = {24'h00_0000, status};
				qci_pkg::OFF_IRQ_EN: rdata_nxt = {24'h00_0000, irq_en_r};
				default:             rdata_nxt = qci_pkg::RDATA_RST;
			endcase
		end
		if (wr_do)
		begin
			unique case (avs_address)
				qci_pkg::OFF_CTRL:
					if (avs_byteenable[0])
						ctrl_nxt = avs_writedata[6:0];
				qci_pkg::OFF_GEN_A:
				begin
					if (avs_byteenable[0])
						gen_a_nxt[7:0] = avs_writedata[7:0];
					if (avs_byteenable[1])
						gen_a_nxt[15:8] = avs_writedata[15:8];
				end
				qci_pkg::OFF_GEN_B:
				begin
					if (avs_byteenable[0])
						gen_b_nxt[7:0] = avs_writedata[7:0];
					if (avs_byteenable[1])
						gen_b_nxt[15:8] = avs_writedata[15:8];
				end
				qci_pkg::OFF_IRQ_EN:
					if (avs_byteenable[0])
						irq_en_nxt = avs_writedata[7:0];
				default:
					irq_en_nxt = irq_en_r;
			endcase
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign avs_readdata    = rdata_r;

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ctrl_r   <= qci_pkg::CTRL_RST;
			count_r  <= qci_pkg::CNT_RST;
			gen_a_r  <= qci_pkg::GEN_RST;
			gen_b_r  <= qci_pkg::GEN_RST;
			flag_r   <= '0;
			dir_r    <= 1'b0;
			irq_en_r <= qci_pkg::IRQ_EN_RST;
			ack_r    <= 1'b0;
			rdata_r  <= qci_pkg::RDATA_RST;
		end
		else
		begin
			ctrl_r   <= ctrl_nxt;
			count_r  <= count_nxt;
			gen_a_r  <= gen_a_nxt;
			gen_b_r  <= gen_b_nxt;
			flag_r   <= flag_nxt;
			dir_r    <= dir_nxt;
			irq_en_r <= irq_en_nxt;
			ack_r    <= ack_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	sequence s_plain_up;
		step.up && !wr_do && !evt.match_a;
	endsequence

	sequence s_plain_dn;
		step.dn && !wr_do && !evt.match_a;
	endsequence

	sequence s_clear_all;
		wr_do && avs_address == qci_pkg::OFF_STATUS && avs_byteenable[0]
			&& avs_writedata[7:0] == 8'hFF && !stepped;
	endsequence

	AST_UP_COUNT: assert property (s_plain_up |=> count_r == $past(count_r) + 16'h0001)
		else $error("up step did not add one");

	AST_DN_COUNT: assert property (s_plain_dn |=> count_r == $past(count_r) - 16'h0001)
		else $error("down step did not subtract one");

	AST_NO_STEP_HOLD: assert property (!stepped && !wr_do |=> $stable(count_r))
		else $error("counter moved without a step");

	AST_PAIR_CD: assert property (run && (chan == qci_pkg::CHAN_2 || chan == qci_pkg::CHAN_4)
		&& step_cd.up |-> step.up)
		else $error("channel 2 or 4 ignored pins C and D");

	AST_BAD_CHAN: assert property (chan == 3'h3 |-> !stepped)
		else $error("counting on a channel without phase mode");

	AST_OVF_FLAG: assert property (step.up && count_r == qci_pkg::CNT_MAX |=>
		flag_r.ovf && count_r == 16'h0000)
		else $error("overflow not flagged");

	AST_UNF_FLAG: assert property (step.dn && count_r == 16'h0000 |=> flag_r.unf)
		else $error("underflow not flagged");

	AST_SET_WINS: assert property (evt.match_a |=> flag_r.match_a)
		else $error("match event lost");

	AST_DIR_FLAG: assert property (step.dn ##1 !stepped |=> status[qci_pkg::ST_DIR] == 1'b0)
		else $error("direction flag wrong after down step");

	AST_IRQ_CLEAR: assert property (s_clear_all ##1 !stepped |-> !irq_o)
		else $error("interrupt stayed after flags cleared");

	AST_IRQ_MASK: assert property (irq_en_r == 8'h00 |-> !irq_o)
		else $error("interrupt with all enables off");

	AST_DMA_ONLY_A: assert property (dma_start_o |-> flag_r.match_a && xfer_start_o)
		else $error("DMA start without match A");

	AST_ORDER: assert property (irq_o && flag_r.match_a && irq_en_r[0] |-> irq_src_o == 2'h0)
		else $error("match A not first in order");

	AST_BUS_ANSWER: assert property ((avs_read || avs_write) && !ack_r |=> !avs_waitrequest)
		else $error("bus not answered after one wait state");

endmodule

`default_nettype wire

// ==== testbench/qci_encoder_model.sv ====
// Two-phase rotary encoder model driving one pair of timer clock pins
`timescale 1ns/1ps
`default_nettype none

module qci_encoder_model
(
	input  wire logic clock_i,  // Bench clock, paces the edges
	output logic      pha_o,    // A phase line, push-pull
	output logic      phb_o     // B phase line, push-pull
);
	// ------------------------------------------------------------
	// Pace and start level
	// ------------------------------------------------------------
	// Cycles each level stands; below two the sampler may miss it
	int unsigned hold_cycles = 3;

	initial
	begin
		pha_o = 1'b0;
		phb_o = 1'b0;
	end

	// ------------------------------------------------------------
	// One phase edge
	// ------------------------------------------------------------
	// Changed right after a clock edge, then held for the pace
	task automatic toggle(input bit on_b);
		@(posedge clock_i);
		if (on_b)
			phb_o <= ~phb_o;
		else
			pha_o <= ~pha_o;
		repeat (hold_cycles) @(posedge clock_i);
	endtask
endmodule
`default_nettype wire

// ==== testbench/quadrature_counter_irq_bench.sv ====
// Self-checking bench for the quadrature counter and its interrupt logic
`timescale 1ns/1ps
`default_nettype none

module quadrature_counter_irq_bench;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic             clock_i;
	logic             rst_i;
	logic [4:0]       avs_address;
	logic             avs_read;
	logic             avs_write;
	logic [31:0]      avs_writedata;
	wire logic [31:0] rdata;
	wire logic        wait_req;
	wire logic        irq;
	wire logic [1:0]  irq_src;
	wire logic        xfer;
	wire logic        dma;
	wire logic        pin_a;
	wire logic        pin_b;
	wire logic        pin_c;
	wire logic        pin_d;
	int               mismatches;
	int               n_compared;
	int               sel;
	logic [15:0]      exp_cnt;
	logic [15:0]      gen_a;
	logic [15:0]      gen_b;
	logic [7:0]       exp_st;
	logic [7:0]       exp_en;

	// ------------------------------------------------------------
	// Design and encoders
	// ------------------------------------------------------------
	qci_counter qci_counter_i (.clock_i(clock_i), .rst_i(rst_i),
		.ext_clk_in_a(pin_a), .ext_clk_in_b(pin_b), .ext_clk_in_c(pin_c),
		.ext_clk_in_d(pin_d), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(rdata), .avs_waitrequest(wait_req), .irq_o(irq),
		.irq_src_o(irq_src), .xfer_start_o(xfer), .dma_start_o(dma));
	// Servo encoder on pins A/B for channel 1
	qci_encoder_model enc_ab (.clock_i(clock_i), .pha_o(pin_a), .phb_o(pin_b));
	qci_encoder_model enc_cd (.clock_i(clock_i), .pha_o(pin_c), .phb_o(pin_d));

	// Free-running 100 MHz clock
	initial
	begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic close_out();
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One Avalon transfer; held until a rising edge sees waitrequest low
	// A hung slave is left to the watchdog, no local limit
	task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d,
		output logic [31:0] q);
		@(posedge clock_i);
		avs_address   <= a;
		avs_writedata <= {16'h0000, d};
		avs_write     <= w;
		avs_read      <= ~w;
		@(posedge clock_i);
		while (wait_req !== 1'b0)
			@(posedge clock_i);
		q = rdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 16'h0000, q);
		chk(q, e);
	endtask

	// Program a channel; sel names the encoder that should count
	task automatic setup(input logic mode, input logic [2:0] ch, input logic [15:0] cnt);
		wr(qci_pkg::OFF_CTRL, {9'h000, ch, 3'h0, mode});
		wr(qci_pkg::OFF_COUNT, cnt);
		exp_cnt = cnt;
		sel = -1;
		if (mode && (ch == 3'h1 || ch == 3'h5))
			sel = 0;
		if (mode && (ch == 3'h2 || ch == 3'h4))
			sel = 1;
	endtask

	// One phase edge and its expected effect
	task automatic step(input int e, input bit on_b);
		logic up;
		if (e == 0)
			enc_ab.toggle(on_b);
		else
			enc_cd.toggle(on_b);
		up = (e == 0) ? (pin_a == pin_b) : (pin_c == pin_d);
		if (on_b && e == sel)
		begin
			if (up && exp_cnt == 16'hFFFF)
				exp_st[qci_pkg::ST_OVF] = 1'b1;
			if (!up && exp_cnt == 16'h0000)
				exp_st[qci_pkg::ST_UNF] = 1'b1;
			exp_cnt = up ? exp_cnt + 16'h0001 : exp_cnt - 16'h0001;
			exp_st[qci_pkg::ST_DIR] = up;
			if (exp_cnt == gen_a)
				exp_st[qci_pkg::ST_MATCH_A] = 1'b1;
			if (exp_cnt == gen_b)
				exp_st[qci_pkg::ST_MATCH_B] = 1'b1;
		end
	endtask

	task automatic clr(input logic [7:0] bits);
		wr(qci_pkg::OFF_STATUS, {8'h00, bits});
		exp_st = exp_st & ~(bits & 8'h7F);
	endtask

	task automatic en(input logic [7:0] bits);
		wr(qci_pkg::OFF_IRQ_EN, {8'h00, bits});
		exp_en = bits;
	endtask

	// Counter, flags and request lines after the pins have settled
	task automatic check_all();
		logic [7:0] p;
		logic [1:0] s;
		repeat (6) @(posedge clock_i);
		rd_chk(qci_pkg::OFF_COUNT, {16'h0000, exp_cnt});
		rd_chk(qci_pkg::OFF_STATUS, {24'h00_0000, exp_st});
		p = exp_st & exp_en & 8'h33;
		s = p[qci_pkg::ST_MATCH_A] ? qci_pkg::SRC_MATCH_A :
			p[qci_pkg::ST_MATCH_B] ? qci_pkg::SRC_MATCH_B :
			p[qci_pkg::ST_OVF] ? qci_pkg::SRC_OVF : qci_pkg::SRC_UNF;
		chk(irq, |p);
		chk(irq_src, s);
		chk(xfer, p[qci_pkg::ST_MATCH_A] | p[qci_pkg::ST_MATCH_B]);
		chk(dma, p[qci_pkg::ST_MATCH_A]);
	endtask

	// ------------------------------------------------------------
	// Watchdog: the tests need well under a thousand cycles
	// ------------------------------------------------------------
	initial
	begin
		repeat (20000) @(posedge clock_i);
		mismatches++;
		$display("CHECK FAILED at %0t: run did not finish", $time);
		close_out();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		rst_i = 1'b1;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		mismatches = 0;
		n_compared = 0;
		sel = -1;
		exp_cnt = 16'h0000;
		gen_a = 16'hFFFF;
		gen_b = 16'hFFFF;
		exp_st = 8'h00;
		exp_en = 8'h00;
		repeat (10) @(posedge clock_i);
		rst_i <= 1'b0;
		// Reset state, and an unmapped place that ignores writes
		wr(5'h18, 16'hA5A5);
		rd_chk(5'h18, 32'h0000_0000);
		rd_chk(qci_pkg::OFF_CTRL, 32'h0000_0000);
		rd_chk(qci_pkg::OFF_GEN_A, 32'h0000_FFFF);
		rd_chk(qci_pkg::OFF_IRQ_EN, 32'h0000_0000);
		check_all();
		// Every channel number, counting on and off
		step(1, 1'b0);
		for (int ch = 0; ch < 8; ch++)
		begin
			setup(1'b1, ch[2:0], 16'h0100);
			step(0, 1'b1);
			step(1, 1'b1);
			check_all();
		end
		setup(1'b0, 3'h1, 16'h0100);
		step(0, 1'b1);
		check_all();
		// Down then up, slow encoder on the way up
		setup(1'b1, 3'h1, 16'h0010);
		for (int i = 0; i < 4; i++)
			step(0, i[0]);
		check_all();
		enc_ab.hold_cycles = 8;
		for (int i = 0; i < 4; i++)
			step(0, ~i[0]);
		check_all();
		enc_ab.hold_cycles = 3;
		// Overflow: set, masked, cleared
		wr(qci_pkg::OFF_GEN_A, 16'h0005);
		gen_a = 16'h0005;
		wr(qci_pkg::OFF_GEN_B, 16'h0006);
		gen_b = 16'h0006;
		setup(1'b1, 3'h1, 16'hFFFF);
		en(8'h10);
		step(0, 1'b1);
		check_all();
		en(8'h00);
		check_all();
		clr(8'h10);
		en(8'h10);
		check_all();
		// Underflow with its own enable
		setup(1'b1, 3'h1, 16'h0000);
		step(0, 1'b1);
		en(8'h30);
		check_all();
		clr(8'h20);
		// Both matches pending: fixed order, transfer starts
		setup(1'b1, 3'h1, 16'h0004);
		step(0, 1'b1);
		en(8'h33);
		check_all();
		step(0, 1'b0);
		step(0, 1'b1);
		check_all();
		clr(8'h01);
		check_all();
		clr(8'h02);
		check_all();
		// Clear on match A: the matching step lands at zero
		wr(qci_pkg::OFF_CTRL, 16'h0013);
		wr(qci_pkg::OFF_COUNT, 16'h0004);
		exp_cnt = 16'h0004;
		step(0, 1'b0);
		step(0, 1'b1);
		exp_cnt = 16'h0000;
		check_all();
		clr(8'hFF);
		check_all();
		close_out();
	end
endmodule
`default_nettype wire
